// File: src/instr_fmt_map.svh
/*
  Constants for the instruction format and cycle-timing block: word widths,
  field positions, opcode-class codes and cycle counts.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef INSTR_FMT_MAP_SVH
`define INSTR_FMT_MAP_SVH

`define WORD_W 24
`define OPC_W 8
`define OPC_MSB 23
`define OPC_LSB 16
`define OPND_W 16
`define REG_IDX_W 4
`define LIT_W 16
`define CYC_W 2

// Field positions inside a single word
`define DST_LSB 7
`define BASE_LSB 11
`define SRC_LSB 0
`define MODE_SRC_LSB 4
`define MODE_DST_LSB 15
`define MODE_W 3
`define FILE_ADDR_W 13
`define FILE_DIR_BIT 13
`define BITSEL_LSB 12
`define BITSEL_W 4
`define BIT_IND_BIT 15
`define LIT_LSB 4
`define LIT_FIELD_W 10
`define ACC_BIT 15
`define XPF_LSB 6
`define YPF_LSB 2
`define PF_W 4
`define XD_LSB 12
`define YD_LSB 10
`define PD_W 2
`define MUL_LSB 16
`define MUL_W 3
`define AWB_LSB 0
`define AWB_W 2
`define SHIFT_LIT_LSB 0
`define SHIFT_W 6
`define SHIFT_LIT_BIT 14
`define TBL_MODE_LSB 14
`define TBL_MODE_W 2

// Opcode classes, taken from the top nibble of the opcode
`define CLS_CTRL 4'h0
`define CLS_BIT 4'ha
`define CLS_LIT 4'hb
`define CLS_MAC 4'hc
`define CLS_DSP 4'hd
`define CLS_FILE 4'he
`define CLS_WORKING_REGISTER_ZERO_LO 4'h4
`define CLS_WORKING_REGISTER_ZERO_HI 4'h7

// Control opcodes
`define OP_NOP 8'h00
`define OP_CALL2 8'h02
`define OP_GOTO2 8'h04
`define OP_RETURN 8'h06
`define OP_JUMP 8'h37
`define OP_IND_CALL 8'h01
`define OP_IND_GOTO 8'h05
`define OP_TBL_RD 8'h0b
`define OP_TBL_WR 8'h0c
`define OP_INT_RET 8'h07
`define OP_DO_MOV2 8'h08
`define OP_SKIP 8'h0e
`define SECOND_HI 8'h00

// Cycle counts
`define CYC_ONE 2'h1
`define CYC_TWO 2'h2
`define CYC_THREE 2'h3

`endif

// File: src/instr_fmt_pkg.sv
/*
  Types for the instruction format block.
  Assumes the constants header is on the include path.
*/
`include "instr_fmt_map.svh"
package instr_fmt_pkg;
  typedef enum logic [5:0] {
    CLASS_CTRL = 6'h01,
    CLASS_WORKING_REGISTER_ZERO = 6'h02,
    CLASS_FILE = 6'h04,
    CLASS_BIT = 6'h08,
    CLASS_LIT = 6'h10,
    CLASS_DSP = 6'h20
  } instr_class_e;

  typedef enum logic [3:0] {
    ST_FIRST = 4'h1,
    ST_SECOND = 4'h2,
    ST_FILL = 4'h4,
    ST_SKIP = 4'h8
  } seq_state_e;
endpackage : instr_fmt_pkg

// File: src/instruction_format_timing.sv
/*
  Instruction format and cycle-timing decoder. Takes one program word per
  instruction cycle, splits it into opcode and operand fields, pairs
  two-word instructions and inserts no-operation cycles.
  Assumes program memory presents a word with word_valid_i every cycle it
  has one, and execute logic reports branch-taken and skip-taken conditions
  in the cycle the deciding word is presented.
*/
`include "instr_fmt_map.svh"

module instruction_format_timing
  import instr_fmt_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Program memory side
  input wire logic [`WORD_W-1:0] word_i,
  input wire logic word_valid_i,
  // Execute feedback
  input wire logic cond_true_i,
  input wire logic skip_taken_i,
  input wire logic three_cycle_i,
  // Decoded instruction
  output logic issue_o,
  output logic nop_o,
  output logic [5:0] class_o,
  output logic [`OPC_W-1:0] opcode_o,
  output logic [`OPND_W-1:0] operand_o,
  output logic [`OPND_W-1:0] ext_operand_o,
  output logic [`CYC_W-1:0] cycles_o,
  // Operand fields
  output logic [`REG_IDX_W-1:0] base_register_o,
  output logic [`REG_IDX_W-1:0] source_register_o,
  output logic [`REG_IDX_W-1:0] dest_register_o,
  output logic [`MODE_W-1:0] src_mode_o,
  output logic [`MODE_W-1:0] dst_mode_o,
  output logic [`FILE_ADDR_W-1:0] file_addr_o,
  output logic to_working_register_zero_o,
  output logic [`BITSEL_W-1:0] bit_sel_o,
  output logic bit_indirect_o,
  output logic [`LIT_FIELD_W-1:0] literal_o,
  output logic has_dest_o,
  output logic acc_b_o,
  output logic [`MUL_W-1:0] mul_pair_o,
  output logic [`PF_W-1:0] x_prefetch_o,
  output logic [`PF_W-1:0] y_prefetch_o,
  output logic [`PD_W-1:0] x_dest_o,
  output logic [`PD_W-1:0] y_dest_o,
  output logic [`AWB_W-1:0] acc_writeback_o,
  output logic [`SHIFT_W-1:0] shift_amount_o,
  output logic shift_literal_o,
  output logic [`REG_IDX_W-1:0] shift_count_register_o,
  output logic [`TBL_MODE_W-1:0] table_mode_o
);

  logic rst_meta_reg;
  logic rst_sync_reg;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // Field split of the incoming word
  wire [`OPC_W-1:0] opc = word_i[`OPC_MSB:`OPC_LSB];
  wire [`OPND_W-1:0] opnd = word_i[`OPND_W-1:0];
  wire [3:0] cls_nib = opc[7:4];
  wire is_two_word = (opc == `OP_CALL2) || (opc == `OP_GOTO2) || (opc == `OP_DO_MOV2);
  wire is_multi = (opc == `OP_JUMP) || (opc == `OP_IND_CALL) || (opc == `OP_IND_GOTO)
               || (opc == `OP_TBL_RD) || (opc == `OP_TBL_WR)
               || (opc == `OP_RETURN) || (opc == `OP_INT_RET);
  wire is_table = (opc == `OP_TBL_RD) || (opc == `OP_TBL_WR);
  wire is_skip = (opc == `OP_SKIP);
  wire is_working_register_zero = (cls_nib >= `CLS_WORKING_REGISTER_ZERO_LO) && (cls_nib <= `CLS_WORKING_REGISTER_ZERO_HI);
  wire is_mac = (cls_nib == `CLS_MAC);

  wire [5:0] dec_class =
    is_working_register_zero ? CLASS_WORKING_REGISTER_ZERO :
    (cls_nib == `CLS_FILE) ? CLASS_FILE :
    (cls_nib == `CLS_BIT) ? CLASS_BIT :
    (cls_nib == `CLS_LIT) ? CLASS_LIT :
    (is_mac || cls_nib == `CLS_DSP) ? CLASS_DSP : CLASS_CTRL;

  // Cycle count for a first word; two-word pairs are always two cycles
  wire [`CYC_W-1:0] single_cycles =
    is_multi ? (three_cycle_i ? `CYC_THREE : `CYC_TWO) :
    (cond_true_i ? `CYC_TWO : `CYC_ONE);
  wire [`CYC_W-1:0] dec_cycles = is_two_word ? `CYC_TWO : single_cycles;

  seq_state_e state_reg;
  seq_state_e state_next;
  logic [`CYC_W-1:0] fill_reg;
  logic [`CYC_W-1:0] fill_next;

  // A skipped pair needs to swallow both words, hence the extra wait state
  always_comb begin
    state_next = state_reg;
    fill_next = fill_reg;
    case (state_reg)
      ST_FIRST: begin
        if (word_valid_i) begin
          if (is_two_word) begin
            state_next = ST_SECOND;
          end else if (is_skip && skip_taken_i) begin
            state_next = ST_SKIP;
          end else if (single_cycles != `CYC_ONE) begin
            state_next = ST_FILL;
            fill_next = single_cycles - `CYC_ONE;
          end
        end
      end
      ST_SECOND: begin
        if (word_valid_i) begin
          state_next = ST_FIRST;
        end
      end
      ST_SKIP: begin
        if (word_valid_i) begin
          if (is_two_word) begin
            state_next = ST_FILL;
            fill_next = `CYC_ONE;
          end else begin
            state_next = ST_FIRST;
          end
        end
      end
      ST_FILL: begin
        if (word_valid_i) begin
          fill_next = fill_reg - `CYC_ONE;
          if (fill_reg == `CYC_ONE) begin
            state_next = ST_FIRST;
          end
        end
      end
      default: begin
        state_next = ST_FIRST;
      end
    endcase
  end

  // Output conditions
  wire first_ok = (state_reg == ST_FIRST) && word_valid_i;
  wire lone_second = first_ok && (opc == `SECOND_HI) && !is_multi && !is_skip
                     && !is_two_word && (opnd != 16'h0000);
  wire take_first = first_ok && !lone_second;
  wire take_second = (state_reg == ST_SECOND) && word_valid_i;
  wire fill_cycle = word_valid_i && ((state_reg == ST_FILL) || (state_reg == ST_SKIP)
                    || lone_second);

  always_ff @(posedge mclk_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      state_reg <= ST_FIRST;
      fill_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      fill_reg <= fill_next;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      issue_o <= 1'b0;
      nop_o <= 1'b0;
      class_o <= CLASS_CTRL;
      opcode_o <= 8'h00;
      operand_o <= 16'h0000;
      ext_operand_o <= 16'h0000;
      cycles_o <= 2'h0;
    end else begin
      issue_o <= take_first;
      nop_o <= fill_cycle;
      if (take_first) begin
        class_o <= dec_class;
        opcode_o <= opc;
        operand_o <= opnd;
        cycles_o <= dec_cycles;
        ext_operand_o <= 16'h0000;
      end
      if (take_second) begin
        ext_operand_o <= opnd;
      end
    end
  end

  // Operand fields, decoded from every word and held from the first word on
  wire [`REG_IDX_W-1:0] base_next = opnd[`BASE_LSB +: `REG_IDX_W];
  wire [`REG_IDX_W-1:0] source_next = opnd[`SRC_LSB +: `REG_IDX_W];
  wire [`REG_IDX_W-1:0] dest_next = opnd[`DST_LSB +: `REG_IDX_W];
  wire [`MODE_W-1:0] src_mode_next = opnd[`MODE_SRC_LSB +: `MODE_W];
  wire [`MODE_W-1:0] dst_mode_next = {opnd[`MODE_DST_LSB], opnd[`BASE_LSB-1 +: 2]};
  wire [`FILE_ADDR_W-1:0] file_addr_next = opnd[`FILE_ADDR_W-1:0];
  wire to_wrz_next = (dec_class == CLASS_FILE) && !opnd[`FILE_DIR_BIT];
  wire [`BITSEL_W-1:0] bit_sel_next = opnd[`BITSEL_LSB +: `BITSEL_W];
  wire bit_ind_next = (dec_class == CLASS_BIT) && opnd[`BIT_IND_BIT];
  wire [`LIT_FIELD_W-1:0] literal_next = opnd[`LIT_LSB +: `LIT_FIELD_W];
  wire has_dest_next = (dec_class == CLASS_LIT) && (dest_next != base_next);
  wire acc_b_next = opnd[`ACC_BIT];
  wire [`MUL_W-1:0] mul_pair_next = word_i[`MUL_LSB +: `MUL_W];
  wire [`PF_W-1:0] x_pf_next = opnd[`XPF_LSB +: `PF_W];
  wire [`PF_W-1:0] y_pf_next = opnd[`YPF_LSB +: `PF_W];
  wire [`PD_W-1:0] x_dest_next = opnd[`XD_LSB +: `PD_W];
  wire [`PD_W-1:0] y_dest_next = opnd[`YD_LSB +: `PD_W];
  wire [`AWB_W-1:0] acc_wb_next = opnd[`AWB_LSB +: `AWB_W];
  wire [`SHIFT_W-1:0] shift_next = opnd[`SHIFT_LIT_LSB +: `SHIFT_W];
  wire shift_lit_next = opnd[`SHIFT_LIT_BIT];
  wire [`REG_IDX_W-1:0] shift_reg_next = opnd[`SRC_LSB +: `REG_IDX_W];
  wire [`TBL_MODE_W-1:0] table_mode_next = is_table ? opnd[`TBL_MODE_LSB +: `TBL_MODE_W]
                                                     : 2'h0;

  field_hold #(.W(`REG_IDX_W)) base_hold (
    .mclk_i(mclk_i), .rst_n_i(rst_sync_reg), .load_i(take_first),
    .d_i(base_next), .q_o(base_register_o)
  );
  field_hold #(.W(`REG_IDX_W)) source_hold (
    .mclk_i(mclk_i), .rst_n_i(rst_sync_reg), .load_i(take_first),
    .d_i(source_next), .q_o(source_register_o)
  );
  field_hold #(.W(`REG_IDX_W)) dest_hold (
    .mclk_i(mclk_i), .rst_n_i(rst_sync_reg), .load_i(take_first),
    .d_i(dest_next), .q_o(dest_register_o)
  );
  field_hold #(.W(`MODE_W)) src_mode_hold (
    .mclk_i(mclk_i), .rst_n_i(rst_sync_reg), .load_i(take_first),
    .d_i(src_mode_next), .q_o(src_mode_o)
  );
  field_hold #(.W(`MODE_W)) dst_mode_hold (
    .mclk_i(mclk_i), .rst_n_i(rst_sync_reg), .load_i(take_first),
    .d_i(dst_mode_next), .q_o(dst_mode_o)
  );
  field_hold #(.W(`FILE_ADDR_W)) file_addr_hold (
    .mclk_i(mclk_i), .rst_n_i(rst_sync_reg), .load_i(take_first),
    .d_i(file_addr_next), .q_o(file_addr_o)
  );
  field_hold #(.W(1)) to_wrz_hold (
    .mclk_i(mclk_i), .rst_n_i(rst_sync_reg), .load_i(take_first),
    .d_i(to_wrz_next), .q_o(to_working_register_zero_o)
  );
  field_hold #(.W(`BITSEL_W)) bit_sel_hold (
    .mclk_i(mclk_i), .rst_n_i(rst_sync_reg), .load_i(take_first),
    .d_i(bit_sel_next), .q_o(bit_sel_o)
  );
  field_hold #(.W(1)) bit_ind_hold (
    .mclk_i(mclk_i), .rst_n_i(rst_sync_reg), .load_i(take_first),
    .d_i(bit_ind_next), .q_o(bit_indirect_o)
  );
  field_hold #(.W(`LIT_FIELD_W)) literal_hold (
    .mclk_i(mclk_i), .rst_n_i(rst_sync_reg), .load_i(take_first),
    .d_i(literal_next), .q_o(literal_o)
  );
  field_hold #(.W(1)) has_dest_hold (
    .mclk_i(mclk_i), .rst_n_i(rst_sync_reg), .load_i(take_first),
    .d_i(has_dest_next), .q_o(has_dest_o)
  );
  field_hold #(.W(1)) acc_b_hold (
    .mclk_i(mclk_i), .rst_n_i(rst_sync_reg), .load_i(take_first),
    .d_i(acc_b_next), .q_o(acc_b_o)
  );
  field_hold #(.W(`MUL_W)) mul_pair_hold (
    .mclk_i(mclk_i), .rst_n_i(rst_sync_reg), .load_i(take_first),
    .d_i(mul_pair_next), .q_o(mul_pair_o)
  );
  field_hold #(.W(`PF_W)) x_pf_hold (
    .mclk_i(mclk_i), .rst_n_i(rst_sync_reg), .load_i(take_first),
    .d_i(x_pf_next), .q_o(x_prefetch_o)
  );
  field_hold #(.W(`PF_W)) y_pf_hold (
    .mclk_i(mclk_i), .rst_n_i(rst_sync_reg), .load_i(take_first),
    .d_i(y_pf_next), .q_o(y_prefetch_o)
  );
  field_hold #(.W(`PD_W)) x_dest_hold (
    .mclk_i(mclk_i), .rst_n_i(rst_sync_reg), .load_i(take_first),
    .d_i(x_dest_next), .q_o(x_dest_o)
  );
  field_hold #(.W(`PD_W)) y_dest_hold (
    .mclk_i(mclk_i), .rst_n_i(rst_sync_reg), .load_i(take_first),
    .d_i(y_dest_next), .q_o(y_dest_o)
  );
  field_hold #(.W(`AWB_W)) acc_wb_hold (
    .mclk_i(mclk_i), .rst_n_i(rst_sync_reg), .load_i(take_first),
    .d_i(acc_wb_next), .q_o(acc_writeback_o)
  );
  field_hold #(.W(`SHIFT_W)) shift_hold (
    .mclk_i(mclk_i), .rst_n_i(rst_sync_reg), .load_i(take_first),
    .d_i(shift_next), .q_o(shift_amount_o)
  );
  field_hold #(.W(1)) shift_lit_hold (
    .mclk_i(mclk_i), .rst_n_i(rst_sync_reg), .load_i(take_first),
    .d_i(shift_lit_next), .q_o(shift_literal_o)
  );
  field_hold #(.W(`REG_IDX_W)) shift_reg_hold (
    .mclk_i(mclk_i), .rst_n_i(rst_sync_reg), .load_i(take_first),
    .d_i(shift_reg_next), .q_o(shift_count_register_o)
  );
  field_hold #(.W(`TBL_MODE_W)) table_mode_hold (
    .mclk_i(mclk_i), .rst_n_i(rst_sync_reg), .load_i(take_first),
    .d_i(table_mode_next), .q_o(table_mode_o)
  );

endmodule : instruction_format_timing

module field_hold #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Capture strobe and value
  input wire logic load_i,
  input wire logic [W-1:0] d_i,
  // Held field
  output logic [W-1:0] q_o
);

  // Fields stand until the next issue, so a fill or skip cycle cannot disturb them
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_o <= '0;
    end else if (load_i) begin
      q_o <= d_i;
    end
  end

endmodule : field_hold

// File: bench/instr_fmt_checker.sv
/* Port assertions for the instruction decoder.
   Assumes it is bound onto instruction_format_timing. */
module instr_fmt_checker
  import instr_fmt_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [23:0] word_i,
  input wire logic word_valid_i,
  input wire logic cond_true_i,
  input wire logic three_cycle_i,
  input wire logic issue_o,
  input wire logic nop_o,
  input wire logic [5:0] class_o,
  input wire logic [7:0] opcode_o,
  input wire logic [15:0] operand_o,
  input wire logic [15:0] ext_operand_o,
  input wire logic [1:0] cycles_o,
  input wire logic to_working_register_zero_o,
  input wire logic has_dest_o,
  input wire logic [3:0] base_register_o,
  input wire logic [3:0] dest_register_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  wire two_w = opcode_o inside {8'h02, 8'h04, 8'h08};
  wire multi = opcode_o inside {8'h37, 8'h01, 8'h05, 8'h0b, 8'h0c, 8'h06, 8'h07};
  wire is_working_register_zero = class_o == CLASS_WORKING_REGISTER_ZERO;
  issue_taken_a: assert property (issue_o |-> $past(word_valid_i))
    else $error("issue without a word");
  field_split_a: assert property (issue_o |-> opcode_o == $past(word_i[23:16])
    && operand_o == $past(word_i[15:0])) else $error("field split wrong");
  working_register_zero_cycles_a: assert property (issue_o && is_working_register_zero |->
    cycles_o == ($past(cond_true_i) ? 2'h2 : 2'h1)) else $error("single cycles wrong");
  fill_nop_a: assert property (issue_o && is_working_register_zero && cycles_o == 2'h2 && word_valid_i
    |=> nop_o && !issue_o) else $error("fill cycle missing");
  multi_cycles_a: assert property (issue_o && multi |->
    cycles_o == ($past(three_cycle_i) ? 2'h3 : 2'h2)) else $error("multi cycles wrong");
  pair_ext_a: assert property (issue_o && two_w && word_valid_i |=> !issue_o && !nop_o
    && ext_operand_o == $past(word_i[15:0])) else $error("second word lost");
  pair_cycles_a: assert property (issue_o && two_w |-> cycles_o == 2'h2)
    else $error("pair cycles wrong");
  no_overlap_a: assert property (!(issue_o && nop_o))
    else $error("issue and nop together");
  file_dest_a: assert property (issue_o && class_o == CLASS_FILE |->
    to_working_register_zero_o == !operand_o[13]) else $error("file dest wrong");
  lit_dest_a: assert property (issue_o && class_o == CLASS_LIT |->
    has_dest_o == (dest_register_o != base_register_o)) else $error("lit dest wrong");
  cover property (issue_o && cycles_o == 2'h3);
  cover property (nop_o);
  cover property (issue_o && two_w ##1 !issue_o);
endmodule : instr_fmt_checker

bind instruction_format_timing instr_fmt_checker chk_i (.mclk_i, .rst_n_i, .word_i,
  .word_valid_i, .cond_true_i, .three_cycle_i, .issue_o, .nop_o, .class_o, .opcode_o,
  .operand_o, .ext_operand_o, .cycles_o, .to_working_register_zero_o, .has_dest_o,
  .base_register_o, .dest_register_o);

// File: bench/prog_mem_model.sv
/* Program memory model: plays listed words with execute flags.
   Assumes the bench fills mem before calling play. */
module prog_mem_model (
  input wire logic clk_i,
  output logic [23:0] word_o,
  output logic valid_o,
  output logic cond_o,
  output logic skip_o,
  output logic three_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [26:0] mem [0:3];
  initial begin
    word_o = '0;
    valid_o = 1'b0;
    {three_o, skip_o, cond_o} = '0;
  end
  // Idle cycles flip the word so stale data is never mistaken for held data
  task automatic idle();
    @(posedge clk_i);
    #1 valid_o = 1'b0;
    word_o = ~word_o;
    {three_o, skip_o, cond_o} = '0;
  endtask : idle
  task automatic play(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      repeat (gap) idle();
      @(posedge clk_i);
      #1 {three_o, skip_o, cond_o, word_o} = mem[i];
      valid_o = 1'b1;
    end
    idle();
  endtask : play
endmodule : prog_mem_model

// File: bench/test_instruction_format_timing.sv
/* Self-checking bench for the instruction decoder.
   Assumes package, checker and memory model are compiled first. */
module test_instruction_format_timing;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i, rst_n_i, word_valid_i, cond_true_i, skip_taken_i, three_cycle_i;
  logic issue_o, nop_o, to_working_register_zero_o, bit_indirect_o, has_dest_o;
  logic acc_b_o, shift_literal_o;
  logic [23:0] word_i;
  logic [15:0] ext_operand_o;
  logic [12:0] file_addr_o;
  logic [9:0] literal_o;
  logic [5:0] shift_amount_o, class_o;
  logic [3:0] bit_sel_o, base_register_o, source_register_o, dest_register_o;
  logic [3:0] x_prefetch_o, y_prefetch_o, shift_count_register_o;
  logic [2:0] mul_pair_o, src_mode_o, dst_mode_o;
  logic [1:0] cycles_o, table_mode_o, x_dest_o, y_dest_o, acc_writeback_o;
  int err_count = 0;
  int comparisons = 0;
  int issues, nops;

  prog_mem_model pm (.clk_i(mclk_i), .word_o(word_i), .valid_o(word_valid_i),
    .cond_o(cond_true_i), .skip_o(skip_taken_i), .three_o(three_cycle_i));
  instruction_format_timing dut (.mclk_i, .rst_n_i, .word_i, .word_valid_i, .cond_true_i,
    .skip_taken_i, .three_cycle_i, .issue_o, .nop_o, .class_o, .opcode_o(), .operand_o(),
    .ext_operand_o, .cycles_o, .base_register_o, .source_register_o, .dest_register_o,
    .src_mode_o, .dst_mode_o, .file_addr_o, .to_working_register_zero_o, .bit_sel_o,
    .bit_indirect_o, .literal_o, .has_dest_o, .acc_b_o, .mul_pair_o, .x_prefetch_o,
    .y_prefetch_o, .x_dest_o, .y_dest_o, .acc_writeback_o, .shift_amount_o,
    .shift_literal_o, .shift_count_register_o, .table_mode_o);

  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    if (issue_o === 1'b1) issues++;
    if (nop_o === 1'b1) nops++;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic run(input int n, input int gap);
    issues = 0;
    nops = 0;
    pm.play(n, gap);
    repeat (3) @(posedge mclk_i);
    #2;
  endtask : run
  task automatic one(input logic [23:0] w);
    pm.mem[0] = {3'b000, w};
    run(1, 0);
    chk(issues, 1);
  endtask : one

  task automatic s_working_register_zero();
    pm.mem[0] = {3'b000, 24'h455a93};
    pm.mem[1] = {3'b001, 24'h461234};
    pm.mem[2] = {3'b000, 24'h470000};
    run(3, 0);
    chk(issues, 2);
    chk(nops, 1);
    chk(cycles_o, 2'h2);
    chk(base_register_o, 4'h2);
    chk(dest_register_o, 4'h4);
    chk(source_register_o, 4'h4);
  endtask : s_working_register_zero
  task automatic s_multi();
    logic [7:0] ops [7] = '{8'h37, 8'h01, 8'h05, 8'h0b, 8'h0c, 8'h06, 8'h07};
    for (int i = 0; i < 7; i++) begin
      for (int t = 0; t < 2; t++) begin
        pm.mem[0] = {t[0], 2'b00, ops[i], 16'hc001};
        pm.mem[1] = {3'b000, 24'h450000};
        pm.mem[2] = pm.mem[1];
        run(3, 0);
        chk(nops, 1 + t);
        chk(issues, 2 - t);
        if (t == 1) begin
          chk(cycles_o, 2'h3);
          chk(table_mode_o, ops[i] inside {8'h0b, 8'h0c} ? 2'h3 : 2'h0);
        end
      end
    end
  endtask : s_multi
  task automatic s_pair();
    logic [7:0] ops [3] = '{8'h02, 8'h04, 8'h08};
    for (int i = 0; i < 3; i++) begin
      pm.mem[0] = {3'b000, ops[i], 16'h0102};
      pm.mem[1] = {3'b000, 24'h008abc};
      run(2, i);
      chk(issues, 1);
      chk(nops, 0);
      chk(cycles_o, 2'h2);
      chk(ext_operand_o, 16'h8abc);
    end
  endtask : s_pair
  task automatic s_skip();
    pm.mem[0] = {3'b000, 24'h0e0000};
    pm.mem[1] = {3'b000, 24'h450000};
    pm.mem[2] = {3'b000, 24'h460000};
    run(3, 0);
    chk(issues, 3);
    pm.mem[0] = {3'b010, 24'h0e0000};
    run(3, 0);
    chk(nops, 1);
    pm.mem[1] = {3'b000, 24'h040000};
    pm.mem[2] = {3'b000, 24'h001234};
    pm.mem[3] = {3'b000, 24'h460000};
    run(4, 0);
    chk(issues, 2);
    chk(nops, 2);
  endtask : s_skip
  task automatic s_fields();
    pm.mem[1] = {3'b000, 24'h450000};
    pm.mem[0] = {3'b000, 24'h000042};
    run(2, 0);
    chk(nops, 1);
    one(24'h40cd5a);
    chk(class_o, 6'h02);
    chk(src_mode_o, 3'h5);
    chk(dst_mode_o, 3'h7);
    one(24'he42123);
    chk(class_o, 6'h04);
    chk(to_working_register_zero_o, 1'b0);
    chk(file_addr_o, 13'h0123);
    one(24'ha19abc);
    chk(class_o, 6'h08);
    chk(bit_indirect_o, 1'b1);
    chk(bit_sel_o, 4'h9);
    one(24'hb20885);
    chk(class_o, 6'h10);
    chk(has_dest_o, 1'b0);
    chk(literal_o, 10'h088);
    one(24'hc3b6e5);
    chk(class_o, 6'h20);
    chk(mul_pair_o, 3'h3);
    chk(acc_b_o, 1'b1);
    chk(x_prefetch_o, 4'hb);
    chk(y_prefetch_o, 4'h9);
    chk(x_dest_o, 2'h3);
    chk(y_dest_o, 2'h1);
    chk(acc_writeback_o, 2'h1);
    one(24'hd0402a);
    chk(shift_literal_o, 1'b1);
    chk(shift_amount_o, 6'h2a);
    chk(shift_count_register_o, 4'ha);
  endtask : s_fields

  task automatic stop_test();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  initial begin
    rst_n_i = 1'b0;
    repeat (2) @(posedge mclk_i);
    #1 rst_n_i = 1'b1;
    repeat (3) @(posedge mclk_i);
    #1;
    s_working_register_zero();
    s_multi();
    s_pair();
    s_skip();
    s_fields();
    stop_test();
  end
  // A hang is cut short here and counted
  initial begin
    #200000;
    err_count++;
    stop_test();
  end
endmodule : test_instruction_format_timing
